// ===== rtl/three_pos_pkg.sv
// Purpose: shared constants and types of the three step positioning controller
// Assumes: 125 MHz clock, distances in 0.1 mm steps, times in 0.1 s steps
// Notes:   byte offsets are for a 32-bit AHB-Lite slave, one word per register
package three_pos_pkg;
	// clock rate and time base
	localparam int CLOCK_KHZ       = 125000;
	localparam int TICK_TIME_MS    = 100;
	localparam int TICK_CYCLES_DEF = CLOCK_KHZ * TICK_TIME_MS;

	// widths
	localparam int PRESC_W = 24;
	localparam int TIME_W  = 8;
	localparam int VAL_W   = 16;
	localparam int ADDR_W  = 8;
	localparam int CARD_W  = 7;

	// register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFS    = 8'h00;
	localparam logic [ADDR_W-1:0] THR1_OFS    = 8'h04;
	localparam logic [ADDR_W-1:0] THR2_OFS    = 8'h08;
	localparam logic [ADDR_W-1:0] THR3_OFS    = 8'h0c;
	localparam logic [ADDR_W-1:0] HYST_OFS    = 8'h10;
	localparam logic [ADDR_W-1:0] ON_OFS      = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_OFS     = 8'h18;
	localparam logic [ADDR_W-1:0] JOGF_OFS    = 8'h1c;
	localparam logic [ADDR_W-1:0] CARD_OFS    = 8'h20;
	localparam logic [ADDR_W-1:0] SERVICE_OFS = 8'h24;
	localparam logic [ADDR_W-1:0] ACT_OFS     = 8'h28;

	// field positions
	localparam int CTRL_AUTO_BIT = 0;
	localparam int CTRL_JOGL_BIT = 1;
	localparam int CTRL_JOGR_BIT = 2;
	localparam int ACT_LEFT_BIT  = 0;
	localparam int ACT_RIGHT_BIT = 1;
	localparam int ACT_FAST_BIT  = 2;
	localparam int ACT_STAGE_LSB = 3;
	localparam int HTRANS_ACT_BIT = 1;

	// reset and service-load values, saturation limits, service code
	localparam logic [VAL_W-1:0]  THR1_DEF = 16'h0014;
	localparam logic [VAL_W-1:0]  THR2_DEF = 16'h0028;
	localparam logic [VAL_W-1:0]  THR3_DEF = 16'h003c;
	localparam logic [VAL_W-1:0]  HYST_DEF = 16'h000a;
	localparam logic [VAL_W-1:0]  VAL_MAX  = 16'h4e20;
	localparam logic [TIME_W-1:0] ON_DEF   = 8'h0a;
	localparam logic [TIME_W-1:0] OFF_DEF  = 8'h0a;
	localparam logic [TIME_W-1:0] TIME_MAX = 8'h64;
	localparam logic [CARD_W-1:0] CARD_DEF = 7'h00;
	localparam logic              JOGF_DEF = 1'b0;
	localparam logic [7:0]        SERVICE_CODE = 8'h20;

	typedef enum logic [1:0] {
		STAGE_STOP  = 2'b00,
		STAGE_PULSE = 2'b01,
		STAGE_SLOW  = 2'b10,
		STAGE_FAST  = 2'b11
	} stage_e;
endpackage : three_pos_pkg

// ===== rtl/pulse_if.sv
// Purpose: link between the stage logic and the pulse interval timer
// Assumes: both ends on the same clock
// Notes:   level is combinational from run, on_ticks, off_ticks and the timer's phase flop
`timescale 1ns/1ns
interface pulse_if;
	import three_pos_pkg::*;
	logic              run;
	logic [TIME_W-1:0] on_ticks;
	logic [TIME_W-1:0] off_ticks;
	logic              level;
	modport ctrl  (output run, output on_ticks, output off_ticks, input level);
	modport timer (input run, input on_ticks, input off_ticks, output level);
endinterface : pulse_if

// ===== rtl/pulse_timer.sv
// Purpose: on/off interval generator for the pulsed stage
// Assumes: on_ticks and off_ticks in 0.1 s ticks
// Notes:   on time zero keeps the output low unless off time is also zero, off time zero keeps it high
`timescale 1ns/1ns
module pulse_timer #(
	parameter int TICK_CYCLES = three_pos_pkg::TICK_CYCLES_DEF
) (
	input wire logic clock,
	input wire logic rst,
	pulse_if.timer   pif
);
	import three_pos_pkg::*;

	logic [PRESC_W-1:0] presc_reg;
	logic               phase_on_reg;
	logic [TIME_W-1:0]  phase_cnt_reg;
	logic               tick;
	logic [TIME_W-1:0]  limit;
	logic               phase_end;

	assign tick      = presc_reg == PRESC_W'(TICK_CYCLES - 1);
	assign limit     = phase_on_reg ? pif.on_ticks : pif.off_ticks;
	// a lowered limit ends the phase at the next tick rather than wrapping the count
	assign phase_end = (limit == '0) ||
		(tick && ({1'b0, phase_cnt_reg} + 9'h001 >= {1'b0, limit}));

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			presc_reg <= '0;
		end else if (!pif.run || tick) begin
			presc_reg <= '0;
		end else begin
			presc_reg <= presc_reg + PRESC_W'(1);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase_on_reg  <= 1'b1;
			phase_cnt_reg <= '0;
		end else if (!pif.run) begin
			phase_on_reg  <= 1'b1;
			phase_cnt_reg <= '0;
		end else if (phase_end) begin
			phase_on_reg  <= !phase_on_reg;
			phase_cnt_reg <= '0;
		end else if (tick) begin
			phase_cnt_reg <= phase_cnt_reg + TIME_W'(1);
		end
	end

	assign pif.level = pif.run &&
		((pif.off_ticks == '0) || (phase_on_reg && (pif.on_ticks != '0)));

	a_phase_hold: assert property (@(posedge clock) disable iff (rst)
		pif.run && !tick && (limit != '0) |=> !pif.run || $stable(phase_on_reg))
		else $error("pulse phase changed between ticks");

	a_phase_start: assert property (@(posedge clock) disable iff (rst)
		!pif.run |=> phase_on_reg && (phase_cnt_reg == '0))
		else $error("pulse phase not restarted on entry");
endmodule : pulse_timer

// ===== rtl/three_position_controller.sv
// Purpose: three step web positioning controller with AHB-Lite settings
// Assumes: deviation is signed, 0.1 mm per step, from logic on this clock
// Notes:   left, right and fast go to the output card at out_card_addr
//
// Contract
// - magnitude above threshold 1 drives the direction output pulsed
// - magnitude above threshold 2 drives the direction output continuously
// - magnitude above threshold 3 adds the fast output
// - a threshold of zero disables its stage entirely
// - a stage drops only below its threshold minus the common hysteresis
// - pulsed stage alternates separate on and off intervals up to 10 s
// - jog fast setting adds the fast output while jogging
// - commands go to the output card whose address is set, 0 to 7F
// - the active command is readable as a diagnostic value
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ns
module three_position_controller #(
	parameter int TICK_CYCLES = three_pos_pkg::TICK_CYCLES_DEF
) (
	input  wire logic                            clock,
	input  wire logic                            rst,
	input  wire logic                            hsel,
	input  wire logic [31:0]                     haddr,
	input  wire logic [1:0]                      htrans,
	input  wire logic                            hwrite,
	input  wire logic [2:0]                      hsize,
	input  wire logic [31:0]                     hwdata,
	input  wire logic                            hready,
	output logic                                 hreadyout,
	output logic                                 hresp,
	output logic [31:0]                          hrdata,
	input  wire logic signed [three_pos_pkg::VAL_W-1:0] deviation,
	output logic                                 out_left,
	output logic                                 out_right,
	output logic                                 out_fast,
	output logic [three_pos_pkg::CARD_W-1:0]     out_card_addr
);
	import three_pos_pkg::*;

	function automatic logic [VAL_W-1:0] sat_val(input logic [31:0] w);
		sat_val = (w > {16'h0000, VAL_MAX}) ? VAL_MAX : w[VAL_W-1:0];
	endfunction : sat_val

	function automatic logic [TIME_W-1:0] sat_time(input logic [31:0] w);
		sat_time = (w > {24'h000000, TIME_MAX}) ? TIME_MAX : w[TIME_W-1:0];
	endfunction : sat_time

	function automatic logic stage_next(input logic cur, input logic [VAL_W-1:0] mag,
		input logic [VAL_W-1:0] thr, input logic [VAL_W-1:0] hyst);
		logic [VAL_W:0] off_pt;
		off_pt = {1'b0, thr} - {1'b0, hyst};
		if (thr == '0) begin
			stage_next = 1'b0;
		end else if (mag > thr) begin
			stage_next = 1'b1;
		end else begin
			stage_next = cur && (off_pt[VAL_W] || ({1'b0, mag} >= off_pt));
		end
	endfunction : stage_next

	logic                  wr_pend_reg;
	logic [ADDR_W-1:0]     wr_addr_reg;
	logic                  auto_reg;
	logic                  jog_left_reg;
	logic                  jog_right_reg;
	logic [VAL_W-1:0]      thr1_reg;
	logic [VAL_W-1:0]      thr2_reg;
	logic [VAL_W-1:0]      thr3_reg;
	logic [VAL_W-1:0]      hyst_reg;
	logic [TIME_W-1:0]     on_reg;
	logic [TIME_W-1:0]     off_reg;
	logic                  jog_fast_reg;
	logic                  s1_reg;
	logic                  s2_reg;
	logic                  s3_reg;
	logic [VAL_W-1:0]      mag;
	logic                  neg;
	logic                  addr_ok;
	logic                  take;
	stage_e                stage;
	logic                  left_next;
	logic                  right_next;
	logic                  fast_next;
	logic [31:0]           rd_word;
	pulse_if               pif ();

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addr_ok   = haddr[31:ADDR_W] == '0;
	assign take      = hsel && hready && htrans[HTRANS_ACT_BIT];

	// most negative deviation saturates to VAL_MAX instead of negating to itself
	assign neg = deviation[VAL_W-1];
	assign mag = !neg ? VAL_W'(deviation) :
		(deviation == {1'b1, {(VAL_W-1){1'b0}}}) ? VAL_MAX : VAL_W'(-deviation);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
		end else begin
			wr_pend_reg <= take && hwrite && addr_ok;
			wr_addr_reg <= haddr[ADDR_W-1:0];
		end
	end

	// settings, written in the data phase; out of range thresholds, hysteresis and times saturate
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			auto_reg      <= 1'b0;
			jog_left_reg  <= 1'b0;
			jog_right_reg <= 1'b0;
			thr1_reg      <= THR1_DEF;
			thr2_reg      <= THR2_DEF;
			thr3_reg      <= THR3_DEF;
			hyst_reg      <= HYST_DEF;
			on_reg        <= ON_DEF;
			off_reg       <= OFF_DEF;
			jog_fast_reg  <= JOGF_DEF;
			out_card_addr <= CARD_DEF;
		end else if (wr_pend_reg) begin
			case (wr_addr_reg)
				CTRL_OFS: begin
					auto_reg      <= hwdata[CTRL_AUTO_BIT];
					jog_left_reg  <= hwdata[CTRL_JOGL_BIT];
					jog_right_reg <= hwdata[CTRL_JOGR_BIT];
				end
				THR1_OFS: thr1_reg <= sat_val(hwdata);
				THR2_OFS: thr2_reg <= sat_val(hwdata);
				THR3_OFS: thr3_reg <= sat_val(hwdata);
				HYST_OFS: hyst_reg <= sat_val(hwdata);
				ON_OFS:   on_reg   <= sat_time(hwdata);
				OFF_OFS:  off_reg  <= sat_time(hwdata);
				JOGF_OFS: jog_fast_reg <= hwdata[0];
				CARD_OFS: out_card_addr <= hwdata[CARD_W-1:0];
				SERVICE_OFS: begin
					if (hwdata[7:0] == SERVICE_CODE) begin
						thr1_reg     <= THR1_DEF;
						thr2_reg     <= THR2_DEF;
						thr3_reg     <= THR3_DEF;
						hyst_reg     <= HYST_DEF;
						on_reg       <= ON_DEF;
						off_reg      <= OFF_DEF;
						jog_fast_reg <= JOGF_DEF;
						out_card_addr <= CARD_DEF;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// per stage switch on and hysteresis off
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else if (!auto_reg) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= stage_next(s1_reg, mag, thr1_reg, hyst_reg);
			s2_reg <= stage_next(s2_reg, mag, thr2_reg, hyst_reg);
			s3_reg <= stage_next(s3_reg, mag, thr3_reg, hyst_reg);
		end
	end

	always_comb begin
		if (s3_reg) begin
			stage = STAGE_FAST;
		end else if (s2_reg) begin
			stage = STAGE_SLOW;
		end else if (s1_reg) begin
			stage = STAGE_PULSE;
		end else begin
			stage = STAGE_STOP;
		end
	end

	assign pif.run       = auto_reg && (stage == STAGE_PULSE);
	assign pif.on_ticks  = on_reg;
	assign pif.off_ticks = off_reg;

	pulse_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_timer (
		.clock(clock),
		.rst  (rst),
		.pif  (pif.timer)
	);

	always_comb begin
		left_next  = 1'b0;
		right_next = 1'b0;
		fast_next  = 1'b0;
		if (auto_reg) begin
			case (stage)
				STAGE_STOP: begin
				end
				STAGE_PULSE: begin
					left_next  = pif.level && neg;
					right_next = pif.level && !neg;
				end
				STAGE_SLOW: begin
					left_next  = neg;
					right_next = !neg;
				end
				STAGE_FAST: begin
					left_next  = neg;
					right_next = !neg;
					fast_next  = 1'b1;
				end
				default: begin
				end
			endcase
		end else begin
			left_next  = jog_left_reg && !jog_right_reg;
			right_next = jog_right_reg && !jog_left_reg;
			fast_next  = jog_fast_reg && (jog_left_reg != jog_right_reg);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			out_left  <= 1'b0;
			out_right <= 1'b0;
			out_fast  <= 1'b0;
		end else begin
			out_left  <= left_next;
			out_right <= right_next;
			out_fast  <= fast_next;
		end
	end

	// a read right after a write to the same word returns the old value
	always_comb begin
		rd_word = 32'h00000000;
		case (haddr[ADDR_W-1:0])
			CTRL_OFS: begin
				rd_word[CTRL_AUTO_BIT] = auto_reg;
				rd_word[CTRL_JOGL_BIT] = jog_left_reg;
				rd_word[CTRL_JOGR_BIT] = jog_right_reg;
			end
			THR1_OFS: rd_word[VAL_W-1:0]  = thr1_reg;
			THR2_OFS: rd_word[VAL_W-1:0]  = thr2_reg;
			THR3_OFS: rd_word[VAL_W-1:0]  = thr3_reg;
			HYST_OFS: rd_word[VAL_W-1:0]  = hyst_reg;
			ON_OFS:   rd_word[TIME_W-1:0] = on_reg;
			OFF_OFS:  rd_word[TIME_W-1:0] = off_reg;
			JOGF_OFS: rd_word[0]          = jog_fast_reg;
			CARD_OFS: rd_word[CARD_W-1:0] = out_card_addr;
			ACT_OFS: begin
				rd_word[ACT_LEFT_BIT]  = out_left;
				rd_word[ACT_RIGHT_BIT] = out_right;
				rd_word[ACT_FAST_BIT]  = out_fast;
				rd_word[ACT_STAGE_LSB +: 2] = stage;
			end
			default: rd_word = 32'h00000000;
		endcase
		if (!addr_ok) begin
			rd_word = 32'h00000000;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h00000000;
		end else if (take && !hwrite) begin
			hrdata <= rd_word;
		end
	end

	a_dir_exclusive: assert property (@(posedge clock) disable iff (rst)
		!(out_left && out_right))
		else $error("left and right asserted together");

	a_zero_disable: assert property (@(posedge clock) disable iff (rst)
		$past(thr1_reg == '0) |-> !s1_reg)
		else $error("disabled pulse stage became active");

	a_zero_fast: assert property (@(posedge clock) disable iff (rst)
		$past(thr3_reg == '0) |-> !s3_reg)
		else $error("disabled fast stage became active");

	a_pulse_entry: assert property (@(posedge clock) disable iff (rst)
		auto_reg && (thr1_reg != '0) && (mag > thr1_reg) |=> s1_reg)
		else $error("pulse stage missed switch-on");

	a_slow_cont: assert property (@(posedge clock) disable iff (rst)
		auto_reg && (stage == STAGE_SLOW) |=> (out_left || out_right) && !out_fast)
		else $error("continuous stage output missing");

	a_fast_adds: assert property (@(posedge clock) disable iff (rst)
		auto_reg && (stage == STAGE_FAST) |=> out_fast && (out_left != out_right))
		else $error("fast stage outputs wrong");

	a_hyst_hold: assert property (@(posedge clock) disable iff (rst)
		auto_reg && s2_reg && (thr2_reg != '0) && (hyst_reg <= thr2_reg) &&
		(mag >= thr2_reg - hyst_reg) |=> s2_reg)
		else $error("stage dropped inside hysteresis band");

	a_jog_fast: assert property (@(posedge clock) disable iff (rst)
		!auto_reg && jog_left_reg && !jog_right_reg |=>
		out_left && !out_right && (out_fast == $past(jog_fast_reg)))
		else $error("jog outputs wrong");

	a_card_write: assert property (@(posedge clock) disable iff (rst)
		wr_pend_reg && (wr_addr_reg == CARD_OFS) |=>
		out_card_addr == $past(hwdata[CARD_W-1:0]))
		else $error("output card address not taken");

	a_act_read: assert property (@(posedge clock) disable iff (rst)
		take && !hwrite && addr_ok && (haddr[ADDR_W-1:0] == ACT_OFS) |=>
		hrdata[ACT_FAST_BIT:ACT_LEFT_BIT] == {$past(out_fast), $past(out_right), $past(out_left)})
		else $error("active command readback wrong");
endmodule : three_position_controller

// ===== tb/output_card_model.sv
// Purpose: behavioural output card taking the positioning commands
// Assumes: one card, answering at CARD_ADDR
// Notes:   drives actuators only while addressed, else all off
`timescale 1ns/1ns
module output_card_model #(
	parameter logic [6:0] CARD_ADDR = 7'h35,
	parameter int         USAGE     = 15
) (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [6:0] card_addr,
	input  wire logic       left,
	input  wire logic       right,
	input  wire logic       fast,
	output logic [2:0]      drive,
	output logic            clash
);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			drive <= 3'h0;
		end else if (card_addr == CARD_ADDR && USAGE == 15) begin
			drive <= {fast, right, left};
		end else begin
			drive <= 3'h0;
		end
	end
	// both directions would fight the motor
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			clash <= 1'b0;
		end else if (left && right) begin
			clash <= 1'b1;
		end
	end
endmodule : output_card_model

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the three step positioning controller
// Assumes: short tick of TICKS clocks, default thresholds 20/40/60, hyst 10
// Notes:   random deviations from a fixed seed plus corner values
`timescale 1ns/1ns
module tb_top;
	import three_pos_pkg::*;
	localparam int TICKS = 4;
	logic                    clock;
	logic                    rst;
	logic                    hsel;
	logic [31:0]             haddr;
	logic [1:0]              htrans;
	logic                    hwrite;
	logic [2:0]              hsize;
	logic [31:0]             hwdata;
	wire logic               hready;
	logic                    hreadyout;
	logic                    hresp;
	logic [31:0]             hrdata;
	logic signed [VAL_W-1:0] deviation;
	logic                    out_left;
	logic                    out_right;
	logic                    out_fast;
	logic [CARD_W-1:0]       out_card_addr;
	logic [2:0]              drive;
	logic                    clash;
	logic [31:0]             rq;
	int                      seed;
	int                      bad_count;
	int                      total_checks;
	int                      cycles;
	int                      dv;
	int                      n;
	logic [1:0]              st;
	int                      dtab[6] = '{21, -41, 61, -20, 0, 100};
	int                      htab[5] = '{45, 35, 29, 15, 9};
	logic [1:0]              hexp[5] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h0};
	logic [7:0]              ra[13] = '{CTRL_OFS, THR1_OFS, THR2_OFS, THR3_OFS, HYST_OFS,
		ON_OFS, OFF_OFS, JOGF_OFS, CARD_OFS, SERVICE_OFS, ACT_OFS, 8'h2c, 8'hfc};
	logic [31:0]             rv[13] = '{0, 20, 40, 60, 10, 10, 10, 0, 0, 0, 0, 0, 0};

	assign hready = hreadyout;

	three_position_controller #(.TICK_CYCLES(TICKS)) uut (
		.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .deviation(deviation),
		.out_left(out_left), .out_right(out_right), .out_fast(out_fast),
		.out_card_addr(out_card_addr));

	output_card_model #(.CARD_ADDR(7'h35), .USAGE(15)) card (
		.clock(clock), .rst(rst), .card_addr(out_card_addr), .left(out_left),
		.right(out_right), .fast(out_fast), .drive(drive), .clash(clash));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic results();
		if (bad_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results

	// long hangs end the run as a mismatch
	always @(posedge clock) begin
		cycles++;
		if (cycles >= 20000) begin
			bad_count++;
			results();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// only the bench timeout ends a wait that never sees hready
	task automatic wait_ready();
		@(posedge clock);
		while (hready !== 1'b1) begin
			@(posedge clock);
		end
	endtask : wait_ready

	// address phase held until hready, then data phase until hready again
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'b10;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		rq = hrdata;
		check("hresp", {31'h0, hresp}, 32'h0);
	endtask : bus

	function automatic logic [1:0] stage_of(input int d);
		int m;
		m = (d < 0) ? -d : d;
		return (m > 60) ? 2'h3 : (m > 40) ? 2'h2 : (m > 20) ? 2'h1 : 2'h0;
	endfunction : stage_of

	task automatic settle(input int d);
		deviation <= 16'(d);
		repeat (4) @(posedge clock);
		bus(0, ACT_OFS, 32'h0);
	endtask : settle

	initial begin
		seed = 25543;
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		deviation = 16'sh0000;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		// reset values, read-only places and unmapped reads
		for (int i = 0; i < 13; i++) begin
			bus(0, ra[i], 32'h0);
			check("reset value", rq, rv[i]);
		end
		bus(1, ACT_OFS, 32'hffff_ffff);
		bus(0, ACT_OFS, 32'h0);
		check("act read only", rq, 32'h0);
		for (int i = 0; i < 26; i++) begin
			dv = (i < 6) ? dtab[i] : $random(seed) % 100;
			bus(1, CTRL_OFS, 32'h0);
			deviation <= 16'(dv);
			bus(1, CTRL_OFS, 32'h1);
			settle(dv);
			st = stage_of(dv);
			check("act stage", {30'h0, rq[4:3]}, {30'h0, st});
			check("no clash", {31'h0, out_left & out_right}, 32'h0);
			if (st != 2'h1) begin
				check("right", {31'h0, out_right}, {31'h0, st != 0 && dv > 0});
				check("left", {31'h0, out_left}, {31'h0, st != 0 && dv < 0});
				check("fast", {31'h0, out_fast}, {31'h0, st == 2'h3});
			end
		end
		// hysteresis on the way down, 10 kept under every threshold gap
		for (int i = 0; i < 5; i++) begin
			settle(htab[i]);
			check("hyst stage", {30'h0, rq[4:3]}, {30'h0, hexp[i]});
		end
		bus(1, ON_OFS, 32'h2);
		bus(1, OFF_OFS, 32'h3);
		deviation <= -16'sd30;
		n = 0;
		while (out_left !== 1'b1 && n < 200) begin
			@(negedge clock);
			n++;
		end
		n = 0;
		while (out_left === 1'b1 && n < 200) begin
			@(negedge clock);
			n++;
		end
		check("pulse on", n, 2 * TICKS);
		n = 0;
		while (out_left === 1'b0 && n < 200) begin
			@(negedge clock);
			n++;
		end
		check("pulse off", n, 3 * TICKS);
		// on time zero holds the output low, off time zero holds it high
		@(posedge clock);
		bus(1, ON_OFS, 32'h0);
		repeat (2) @(posedge clock);
		for (int k = 0; k < 8; k++) begin
			check("pulse on zero", {31'h0, out_left}, 32'h0);
			repeat (TICKS) @(posedge clock);
		end
		bus(1, ON_OFS, 32'h2);
		bus(1, OFF_OFS, 32'h0);
		repeat (2) @(posedge clock);
		for (int k = 0; k < 8; k++) begin
			check("pulse off zero", {31'h0, out_left}, 32'h1);
			repeat (TICKS) @(posedge clock);
		end
		// zero thresholds disable the fast stage, then every stage
		bus(1, THR3_OFS, 32'h0);
		settle(300);
		check("thr3 zero", {30'h0, rq[4:3]}, 32'h2);
		check("thr3 zero fast", {31'h0, out_fast}, 32'h0);
		bus(1, THR1_OFS, 32'h0);
		bus(1, THR2_OFS, 32'h0);
		settle(-300);
		check("all zero stage", {30'h0, rq[4:3]}, 32'h0);
		check("all zero left", {31'h0, out_left}, 32'h0);
		// saturation of settings
		bus(1, THR1_OFS, 32'hffff);
		bus(0, THR1_OFS, 32'h0);
		check("thr sat", rq, {16'h0, VAL_MAX});
		bus(1, ON_OFS, 32'hff);
		bus(0, ON_OFS, 32'h0);
		check("time sat", rq, {24'h0, TIME_MAX});
		// jogging, fast option and card address
		for (int j = 0; j < 4; j++) begin
			bus(1, JOGF_OFS, j / 2);
			bus(1, CTRL_OFS, (j % 2) ? 32'h4 : 32'h2);
			bus(1, CARD_OFS, (j % 2) ? 32'h35 : 32'h0);
			repeat (3) @(posedge clock);
			check("jog left", {31'h0, out_left}, {31'h0, j % 2 == 0});
			check("jog right", {31'h0, out_right}, {31'h0, j % 2 == 1});
			check("jog fast", {31'h0, out_fast}, j / 2);
			check("card addr", {25'h0, out_card_addr}, (j % 2) ? 32'h35 : 32'h0);
			check("card drive", {29'h0, drive}, (j % 2) ? (j / 2) * 4 + 2 : 0);
		end
		bus(1, SERVICE_OFS, 32'h20);
		bus(0, THR3_OFS, 32'h0);
		check("svc thr3", rq, 32'h3c);
		bus(0, CARD_OFS, 32'h0);
		check("svc card", rq, 32'h0);
		bus(0, ON_OFS, 32'h0);
		check("svc on", rq, 32'ha);
		check("model clash", {31'h0, clash}, 32'h0);
		results();
	end
endmodule : tb_top
